// ===== ewp_pkg.sv
// Constants, types and state codes of the two-wire EEPROM slave.
// Assumes a 50 MHz system clock and a separate link sampling clock.
package ewp_pkg;
  // Arbitrary device type code, not tied to any product
  localparam logic [3:0] DEV_TYPE_ID = 4'h6;
  localparam int SLOTS = 8;
  localparam int MEM_BYTES = 512;
  localparam logic [8:0] TOP_ADDR = 9'h1FF;
  localparam int PTR_FLAG_BIT = 2;
  localparam int PTR_ROW_LSB = 3;
  localparam int ROW_MB_LSB = 2;
  localparam logic [7:0] ERASED_BYTE = 8'hFF;
  localparam logic [3:0] BYTE_BITS = 4'h8;
  localparam logic [3:0] ACK_PHASE = 4'h9;
  localparam int CLK_HZ = 50_000_000;
  localparam int PROG_TIME_MS = 10;
  localparam int PROG_TIME_LONG_MS = 20;
  localparam int PROG_CYCLES = CLK_HZ / 1000 * PROG_TIME_MS;
  localparam int PROG_LONG_CYCLES = CLK_HZ / 1000 * PROG_TIME_LONG_MS;
  localparam int TMR_W = 20;
  localparam int SYNC_W = 7;
  typedef enum logic [2:0] {
    ST_IDLE, ST_DEV, ST_ADDR, ST_DATA, ST_IGNORE, ST_WAIT
  } ewp_state_e;
endpackage

// ===== ewp_prog_if.sv
// Write request bundle from the link logic to the programming engine.
// Bundle is held stable while a request toggle is outstanding.
`timescale 1ns/1ns
interface ewp_prog_if;
  import ewp_pkg::*;
  logic                        req_tgl;
  logic                        ack_tgl;
  logic                        blk;
  logic                        inhibit;
  logic                        mbyte;
  logic [SLOTS-1:0]            valid;
  logic [SLOTS-1:0][7:0]       addr;
  logic [SLOTS-1:0][7:0]       data;
  modport link (output req_tgl, blk, inhibit, mbyte, valid, addr, data,
                input ack_tgl);
  modport prog (input req_tgl, blk, inhibit, mbyte, valid, addr, data,
                output ack_tgl);
endinterface

// ===== ewp_prog.sv
// Programming engine and byte array on the system clock.
// Assumes a request bundle that stays stable until acknowledged.
`timescale 1ns/1ns
module ewp_prog
  import ewp_pkg::*;
#(
  parameter int PROG_CYCLES_P      = PROG_CYCLES,
  parameter int PROG_LONG_CYCLES_P = PROG_LONG_CYCLES
) (
  input  wire logic clk_sys_in,
  input  wire logic nrst_in,
  input  wire logic protect_enable_in,
  ewp_prog_if.prog  p,
  output logic      busy_out
);
  logic [7:0]       mem [MEM_BYTES];
  logic [7:0]       next_mem [MEM_BYTES];
  logic             req_s1, req_s2, req_seen, next_req_seen;
  logic             pe_s1, pe_s2;
  logic             busy, next_busy;
  logic             ack_tgl, next_ack_tgl;
  logic [TMR_W-1:0] tmr, next_tmr;
  logic [7:0]       ptr;
  logic [7:0]       chk_addr;
  logic             long_cyc;

  assign p.ack_tgl = ack_tgl;
  assign busy_out  = busy;
  assign ptr       = mem[TOP_ADDR];

  always_comb begin
    long_cyc = 1'b0;
    for (int i = 0; i < SLOTS; i++) begin
      if (p.mbyte && p.valid[i] &&
          p.addr[i][7:ROW_MB_LSB] != p.addr[0][7:ROW_MB_LSB]) begin
        long_cyc = 1'b1;
      end
    end
  end

  always_comb begin
    next_mem      = mem;
    next_req_seen = req_seen;
    next_busy     = busy;
    next_ack_tgl  = ack_tgl;
    next_tmr      = tmr;
    chk_addr      = '0;
    if (busy) begin
      if (tmr == '0) begin
        next_busy    = 1'b0;
        next_ack_tgl = ~ack_tgl;
      end else begin
        next_tmr = tmr - 1'b1;
      end
    end else if (req_s2 != req_seen) begin
      next_req_seen = req_s2;
      if (p.inhibit) begin
        next_ack_tgl = ~ack_tgl;
      end else begin
        for (int i = 0; i < SLOTS; i++) begin
          // Multibyte judged by its first byte, page byte by byte
          chk_addr = p.mbyte ? p.addr[0] : p.addr[i];
          // Blocked range from boundary row to top of upper block
          if (p.valid[i] && !(pe_s2 && !ptr[PTR_FLAG_BIT] && p.blk &&
              chk_addr >= {ptr[7:PTR_ROW_LSB], 3'h0})) begin
            next_mem[{p.blk, p.addr[i]}] = p.data[i];
          end
        end
        next_busy = 1'b1;
        next_tmr  = long_cyc ? TMR_W'(PROG_LONG_CYCLES_P - 1)
                             : TMR_W'(PROG_CYCLES_P - 1);
      end
    end
  end

  always_ff @(posedge clk_sys_in or negedge nrst_in) begin
    if (!nrst_in) begin
      for (int i = 0; i < MEM_BYTES; i++) begin
        mem[i] <= ERASED_BYTE;
      end
      req_s1   <= 1'b0;
      req_s2   <= 1'b0;
      req_seen <= 1'b0;
      pe_s1    <= 1'b0;
      pe_s2    <= 1'b0;
      busy     <= 1'b0;
      ack_tgl  <= 1'b0;
      tmr      <= '0;
    end else begin
      mem      <= next_mem;
      req_s1   <= p.req_tgl;
      req_s2   <= req_s1;
      req_seen <= next_req_seen;
      pe_s1    <= protect_enable_in;
      pe_s2    <= pe_s1;
      busy     <= next_busy;
      ack_tgl  <= next_ack_tgl;
      tmr      <= next_tmr;
    end
  end
endmodule

// ===== ewp_top.sv
// Two-wire EEPROM slave: link decoder on the link clock, array on system.
// Assumes open-drain data wired by the bench; serial lines are asynchronous.
`timescale 1ns/1ns
module ewp_top
  import ewp_pkg::*;
#(
  parameter int PROG_CYCLES_P      = PROG_CYCLES,
  parameter int PROG_LONG_CYCLES_P = PROG_LONG_CYCLES
) (
  input  wire logic clk_sys_in,
  input  wire logic nrst_in,
  input  wire logic clk_link_in,
  input  wire logic scl_in,
  input  wire logic sda_in,
  input  wire logic chip_select_low_bit_in,
  input  wire logic chip_select_high_bit_in,
  input  wire logic write_mode_in,
  input  wire logic write_inhibit_pin_in,
  input  wire logic protect_enable_in,
  output logic      sda_out,
  output logic      sda_oe_out,
  output logic      prog_busy_out
);
  ewp_prog_if pif ();

  logic [SYNC_W-1:0]     sync1, sync2;
  logic                  scl_s, sda_s, cs_hi_s, cs_lo_s, mode_s, wc_s, ack_s;
  logic                  scl_p, sda_p;
  logic                  start_c, stop_c, scl_rise, scl_fall;
  ewp_state_e            st, next_st;
  logic [3:0]            bit_cnt, next_bit_cnt;
  logic [7:0]            shreg, next_shreg;
  logic                  blk, next_blk;
  logic [7:0]            start_addr, next_start_addr;
  logic [2:0]            ctr, next_ctr;
  logic [3:0]            cnt, next_cnt;
  logic                  mbyte, next_mbyte;
  logic [SLOTS-1:0]      valid, next_valid;
  logic [SLOTS-1:0][7:0] s_addr, next_s_addr;
  logic [SLOTS-1:0][7:0] s_data, next_s_data;
  logic                  oe, next_oe;
  logic                  req_tgl, next_req_tgl;
  logic                  inhibit, next_inhibit;
  logic                  ack_seen, next_ack_seen;
  logic [2:0]            slot;
  logic [7:0]            baddr;

  // Two-stage synchronisers for pins and the returning acknowledge
  always_ff @(posedge clk_link_in or negedge nrst_in) begin
    if (!nrst_in) begin
      sync1 <= {{(SYNC_W-1){1'b1}}, 1'b0};
      sync2 <= {{(SYNC_W-1){1'b1}}, 1'b0};
      scl_p <= 1'b1;
      sda_p <= 1'b1;
    end else begin
      sync1 <= {scl_in, sda_in, chip_select_high_bit_in,
                chip_select_low_bit_in, write_mode_in,
                write_inhibit_pin_in, pif.ack_tgl};
      sync2 <= sync1;
      scl_p <= scl_s;
      sda_p <= sda_s;
    end
  end

  assign {scl_s, sda_s, cs_hi_s, cs_lo_s, mode_s, wc_s, ack_s} = sync2;

  // Bus condition detection
  assign start_c  = scl_s && scl_p && sda_p && !sda_s;
  assign stop_c   = scl_s && scl_p && !sda_p && sda_s;
  assign scl_rise = scl_s && !scl_p;
  assign scl_fall = !scl_s && scl_p;

  // Slot and byte address of the next data byte
  always_comb begin
    if (mbyte) begin
      slot  = cnt[2:0];
      baddr = 8'(start_addr + {4'h0, cnt});
    end else begin
      slot  = ctr;
      baddr = {start_addr[7:3], ctr};
    end
  end

  always_comb begin
    next_st         = st;
    next_bit_cnt    = bit_cnt;
    next_shreg      = shreg;
    next_blk        = blk;
    next_start_addr = start_addr;
    next_ctr        = ctr;
    next_cnt        = cnt;
    next_mbyte      = mbyte;
    next_valid      = valid;
    next_s_addr     = s_addr;
    next_s_data     = s_data;
    next_oe         = oe;
    next_req_tgl    = req_tgl;
    next_inhibit    = inhibit;
    next_ack_seen   = ack_seen;
    if (st == ST_WAIT) begin
      // Deaf to the bus until programming completes
      if (ack_s != ack_seen) begin
        next_ack_seen = ack_s;
        next_st       = ST_IDLE;
      end
    end else if (start_c) begin
      next_st      = ST_DEV;
      next_bit_cnt = 4'h0;
      next_oe      = 1'b0;
    end else if (stop_c) begin
      next_oe      = 1'b0;
      next_bit_cnt = 4'h0;
      if (st == ST_DATA && valid != '0) begin
        next_req_tgl = ~req_tgl;
        next_inhibit = wc_s;
        next_st      = ST_WAIT;
      end else begin
        next_st = ST_IDLE;
      end
    end else if (scl_fall && bit_cnt == ACK_PHASE) begin
      next_oe      = 1'b0;
      next_bit_cnt = 4'h0;
    end else if (st == ST_DEV || st == ST_ADDR || st == ST_DATA) begin
      if (scl_rise && bit_cnt < BYTE_BITS) begin
        next_shreg   = {shreg[6:0], sda_s};
        next_bit_cnt = bit_cnt + 4'h1;
      end else if (scl_fall && bit_cnt == BYTE_BITS) begin
        next_bit_cnt = ACK_PHASE;
        case (st)
          ST_DEV: begin
            if (shreg[7:4] == DEV_TYPE_ID &&
                shreg[3:2] == {cs_hi_s, cs_lo_s}) begin
              next_oe  = 1'b1;
              next_blk = shreg[1];
              next_st  = shreg[0] ? ST_IGNORE : ST_ADDR;
            end else begin
              next_st = ST_IGNORE;
            end
          end
          ST_ADDR: begin
            next_oe         = 1'b1;
            next_start_addr = shreg;
            next_ctr        = shreg[2:0];
            next_cnt        = 4'h0;
            next_valid      = '0;
            next_mbyte      = mode_s;
            next_st         = ST_DATA;
          end
          ST_DATA: begin
            if (cnt < 4'(SLOTS)) begin
              next_oe           = 1'b1;
              next_s_addr[slot] = baddr;
              next_s_data[slot] = shreg;
              next_valid[slot]  = 1'b1;
              next_ctr          = ctr + 3'h1;
              next_cnt          = cnt + 4'h1;
            end
          end
          default: begin
            next_st = ST_IGNORE;
          end
        endcase
      end
    end
  end

  always_ff @(posedge clk_link_in or negedge nrst_in) begin
    if (!nrst_in) begin
      st         <= ST_IDLE;
      bit_cnt    <= 4'h0;
      shreg      <= 8'h00;
      blk        <= 1'b0;
      start_addr <= 8'h00;
      ctr        <= 3'h0;
      cnt        <= 4'h0;
      mbyte      <= 1'b0;
      valid      <= '0;
      s_addr     <= '0;
      s_data     <= '0;
      oe         <= 1'b0;
      req_tgl    <= 1'b0;
      inhibit    <= 1'b0;
      ack_seen   <= 1'b0;
      sda_out    <= 1'b0;
      sda_oe_out <= 1'b0;
    end else begin
      st         <= next_st;
      bit_cnt    <= next_bit_cnt;
      shreg      <= next_shreg;
      blk        <= next_blk;
      start_addr <= next_start_addr;
      ctr        <= next_ctr;
      cnt        <= next_cnt;
      mbyte      <= next_mbyte;
      valid      <= next_valid;
      s_addr     <= next_s_addr;
      s_data     <= next_s_data;
      oe         <= next_oe;
      req_tgl    <= next_req_tgl;
      inhibit    <= next_inhibit;
      ack_seen   <= next_ack_seen;
      sda_out    <= 1'b0;
      sda_oe_out <= next_oe;
    end
  end

  // Bundle handed to the programming engine
  assign pif.req_tgl = req_tgl;
  assign pif.blk     = blk;
  assign pif.inhibit = inhibit;
  assign pif.mbyte   = mbyte;
  assign pif.valid   = valid;
  assign pif.addr    = s_addr;
  assign pif.data    = s_data;

  ewp_prog #(
    .PROG_CYCLES_P      (PROG_CYCLES_P),
    .PROG_LONG_CYCLES_P (PROG_LONG_CYCLES_P)
  ) u_prog (
    .clk_sys_in        (clk_sys_in),
    .nrst_in           (nrst_in),
    .protect_enable_in (protect_enable_in),
    .p                 (pif.prog),
    .busy_out          (prog_busy_out)
  );
endmodule

// ===== ewp_top_chk.sv
// Assertions on the top ports of the EEPROM slave.
// Assumes a bind into ewp_top; link and system clocks unrelated.
`timescale 1ns/1ns
module ewp_top_chk #(
  parameter int PROG_CYCLES_P      = 40,
  parameter int PROG_LONG_CYCLES_P = 80
) (
  input  wire logic clk_sys_in,
  input  wire logic nrst_in,
  input  wire logic clk_link_in,
  input  wire logic scl_in,
  input  wire logic sda_in,
  input  wire logic sda_out,
  input  wire logic sda_oe_out,
  input  wire logic prog_busy_out
);
  int cnt;
  int next_cnt;
  // Busy length in system cycles
  always_comb begin
    next_cnt = prog_busy_out ? cnt + 1 : 0;
  end
  always_ff @(posedge clk_sys_in or negedge nrst_in) begin
    if (!nrst_in) begin
      cnt <= 0;
    end else begin
      cnt <= next_cnt;
    end
  end
  sda_low_a: assert property (@(posedge clk_link_in)
    disable iff (!nrst_in) sda_out == 1'b0) else $error("sda driven high");
  ack_rise_a: assert property (@(posedge clk_link_in)
    disable iff (!nrst_in) $rose(sda_oe_out) |-> !scl_in)
    else $error("ack began with clock high");
  ack_fall_a: assert property (@(posedge clk_link_in)
    disable iff (!nrst_in) $fell(sda_oe_out) |-> !scl_in)
    else $error("ack ended with clock high");
  ack_steady_a: assert property (@(posedge clk_link_in)
    disable iff (!nrst_in) scl_in && $past(scl_in) |-> $stable(sda_oe_out))
    else $error("data moved with clock high");
  busy_quiet_a: assert property (@(posedge clk_sys_in)
    disable iff (!nrst_in) prog_busy_out |-> !sda_oe_out)
    else $error("answer while programming");
  busy_max_a: assert property (@(posedge clk_sys_in)
    disable iff (!nrst_in) cnt <= PROG_LONG_CYCLES_P)
    else $error("program cycle too long");
  busy_len_a: assert property (@(posedge clk_sys_in)
    disable iff (!nrst_in) $fell(prog_busy_out) |->
    (cnt == PROG_CYCLES_P || cnt == PROG_LONG_CYCLES_P))
    else $error("program cycle length wrong");
  busy_stop_a: assert property (@(posedge clk_sys_in)
    disable iff (!nrst_in) $rose(prog_busy_out) |-> scl_in && sda_in)
    else $error("program began without stop");
  cover property (@(posedge clk_link_in) disable iff (!nrst_in)
    $rose(sda_oe_out));
  cover property (@(posedge clk_sys_in) disable iff (!nrst_in)
    $fell(prog_busy_out) && cnt == PROG_CYCLES_P);
  cover property (@(posedge clk_sys_in) disable iff (!nrst_in)
    $fell(prog_busy_out) && cnt == PROG_LONG_CYCLES_P);
endmodule

bind ewp_top ewp_top_chk #(
  .PROG_CYCLES_P      (PROG_CYCLES_P),
  .PROG_LONG_CYCLES_P (PROG_LONG_CYCLES_P)
) u_chk (
  .clk_sys_in    (clk_sys_in),
  .nrst_in       (nrst_in),
  .clk_link_in   (clk_link_in),
  .scl_in        (scl_in),
  .sda_in        (sda_in),
  .sda_out       (sda_out),
  .sda_oe_out    (sda_oe_out),
  .prog_busy_out (prog_busy_out)
);

// ===== ewp_master.sv
// Bus master model: serial clock and open-drain data.
// Assumes the bench resolves the data wire with a pull-up.
`timescale 1ns/1ns
module ewp_master #(
  parameter int LO = 24,
  parameter int HI = 20
) (
  input  wire logic clk_sys_in,
  input  wire logic sda_in,
  output logic      scl_out,
  output logic      sda_out
);
  initial begin
    scl_out = 1'b1;
    sda_out = 1'b1;
  end
  task automatic w(input int n);
    repeat (n) @(posedge clk_sys_in);
    #2;
  endtask
  // Bus free time, then data falls with clock high
  task automatic start();
    w(LO);
    sda_out = 1'b0;
    w(HI);
    scl_out = 1'b0;
  endtask
  // Data moves only with clock low
  task automatic bit_out(input logic b, output logic s);
    w(1);
    sda_out = b;
    w(LO);
    scl_out = 1'b1;
    w(HI);
    s = sda_in;
    scl_out = 1'b0;
  endtask
  // MSB first, then released ninth bit
  task automatic put_byte(input logic [7:0] b, output logic ack);
    logic s;
    for (int i = 7; i >= 0; i--) begin
      bit_out(b[i], s);
    end
    bit_out(1'b1, s);
    ack = !s;
  endtask
  // Data rises with clock high
  task automatic stop();
    w(1);
    sda_out = 1'b0;
    w(LO);
    scl_out = 1'b1;
    w(HI);
    sda_out = 1'b1;
  endtask
endmodule

// ===== testbench.sv
// Self-checking bench for the EEPROM slave write path.
// Assumes the master model and the bound checker.
`timescale 1ns/1ns
module testbench;
  import ewp_pkg::*;
  localparam int PS = 4500;
  localparam int PL = 9000;
  typedef struct packed {
    logic [7:0] sel;
    logic [7:0] addr;
    logic [1:0] n;
    logic       mode;
    logic       inh;
    logic       ack;
    logic [1:0] bz;
  } ewp_row_s;
  ewp_row_s rows [6] = '{
    '{8'h68, 8'h10, 2'd1, 1'b1, 1'b0, 1'b1, 2'd1},
    '{8'h64, 8'h00, 2'd0, 1'b1, 1'b0, 1'b0, 2'd0},
    '{8'h78, 8'h00, 2'd0, 1'b1, 1'b0, 1'b0, 2'd0},
    '{8'h68, 8'h20, 2'd1, 1'b0, 1'b1, 1'b1, 2'd0},
    '{8'h6A, 8'h03, 2'd2, 1'b1, 1'b0, 1'b1, 2'd2},
    '{8'h6A, 8'h03, 2'd2, 1'b0, 1'b0, 1'b1, 2'd1}};
  logic clk_sys_in = 1'b0;
  logic clk_link_in = 1'b0;
  logic nrst_in = 1'b0;
  logic cs_lo = 1'b0;
  logic cs_hi = 1'b1;
  logic write_mode_in = 1'b1;
  logic inhibit = 1'b0;
  logic protect_en = 1'b0;
  logic scl;
  logic sda_m;
  logic sda_out;
  logic sda_oe_out;
  logic prog_busy_out;
  logic ack;
  wire  sda_w = sda_m & (sda_oe_out ? sda_out : 1'b1);
  int   failures = 0;
  int   n_compared = 0;
  int   busy_cnt = 0;
  int   bz_len [3] = '{0, PS, PL};
  ewp_row_s row;
  always #10 clk_sys_in = ~clk_sys_in;
  always begin
    #7 clk_link_in = 1'b1;
    #8 clk_link_in = 1'b0;
  end
  always @(posedge clk_sys_in) begin
    if (prog_busy_out === 1'b1) busy_cnt <= busy_cnt + 1;
  end
  ewp_top #(.PROG_CYCLES_P(PS), .PROG_LONG_CYCLES_P(PL)) DUT (
    .clk_sys_in              (clk_sys_in),
    .nrst_in                 (nrst_in),
    .clk_link_in             (clk_link_in),
    .scl_in                  (scl),
    .sda_in                  (sda_w),
    .chip_select_low_bit_in  (cs_lo),
    .chip_select_high_bit_in (cs_hi),
    .write_mode_in           (write_mode_in),
    .write_inhibit_pin_in    (inhibit),
    .protect_enable_in       (protect_en),
    .sda_out                 (sda_out),
    .sda_oe_out              (sda_oe_out),
    .prog_busy_out           (prog_busy_out)
  );
  ewp_master mst (
    .clk_sys_in (clk_sys_in),
    .sda_in     (sda_w),
    .scl_out    (scl),
    .sda_out    (sda_m)
  );
  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    n_compared++;
    if (got !== exp) begin
      failures++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic end_of_test();
    $display("compared=%0d failures=%0d", n_compared, failures);
    if (failures == 0 && n_compared > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask
  // Bounded wait for the program cycle to end
  task automatic wait_idle();
    int k = 0;
    mst.w(20);
    while (prog_busy_out !== 1'b0 && k < 20000) begin
      mst.w(1);
      k++;
    end
    if (k == 20000) begin
      check(prog_busy_out, 1'b0);
      end_of_test();
    end
  endtask
  // Full write command, then wait for the program cycle
  task automatic cmd(input logic [7:0] sel, input logic [7:0] addr,
                     input logic [23:0] d, input int n);
    logic a;
    busy_cnt = 0;
    mst.start();
    mst.put_byte(sel, a);
    check(a, 1'b1);
    mst.put_byte(addr, a);
    check(a, 1'b1);
    for (int i = 0; i < n; i++) begin
      mst.put_byte(d[23-8*i -: 8], a);
      check(a, 1'b1);
    end
    mst.stop();
    wait_idle();
  endtask
  initial begin
    repeat (3) @(posedge clk_sys_in);
    #2 nrst_in = 1'b1;
    mst.w(5);
    for (int r = 0; r < 6; r++) begin
      row = rows[r];
      write_mode_in = row.mode;
      inhibit = row.inh;
      busy_cnt = 0;
      mst.start();
      mst.put_byte(row.sel, ack);
      check(ack, row.ack);
      if (row.ack) begin
        mst.put_byte(row.addr, ack);
        check(ack, 1'b1);
        for (int i = 0; i < row.n; i++) begin
          mst.put_byte(8'h3C, ack);
          check(ack, 1'b1);
        end
      end
      mst.stop();
      if (row.bz != 2'd0) begin
        mst.start();
        mst.put_byte(row.sel, ack);
        check(ack, 1'b0);
        mst.stop();
      end
      wait_idle();
      check(busy_cnt, bz_len[row.bz]);
    end
    // Array contents after the table rows
    check(DUT.u_prog.mem[9'h010], 8'h3C);
    check(DUT.u_prog.mem[9'h020], 8'hFF);
    check(DUT.u_prog.mem[9'h104], 8'h3C);
    // Page wrap, then protection set-up and use
    write_mode_in = 1'b0;
    cmd(8'h68, 8'h0E, 24'hA1A2A3, 3);
    check(busy_cnt, PS);
    check(DUT.u_prog.mem[9'h00F], 8'hA2);
    check(DUT.u_prog.mem[9'h008], 8'hA3);
    cmd(8'h6A, 8'hFF, 24'hF00000, 1);
    cmd(8'h6A, 8'hF8, 24'h420000, 1);
    check(DUT.u_prog.mem[9'h1F8], 8'h42);
    protect_en = 1'b1;
    write_mode_in = 1'b1;
    cmd(8'h6A, 8'hEF, 24'h5A5B00, 2);
    check(busy_cnt, PL);
    check(DUT.u_prog.mem[9'h1EF], 8'h5A);
    check(DUT.u_prog.mem[9'h1F0], 8'h5B);
    write_mode_in = 1'b0;
    cmd(8'h6A, 8'hFE, 24'h770000, 2);
    check(DUT.u_prog.mem[9'h1FE], 8'hFF);
    check(DUT.u_prog.mem[9'h1FF], 8'hF0);
    // Chip-select straps moved to the other code
    cs_lo = 1'b1;
    cs_hi = 1'b0;
    mst.start();
    mst.put_byte(8'h64, ack);
    check(ack, 1'b1);
    mst.stop();
    mst.start();
    mst.put_byte(8'h68, ack);
    check(ack, 1'b0);
    mst.stop();
    cs_lo = 1'b0;
    cs_hi = 1'b1;
    // Reset in mid program cycle, then poll and address-only command
    mst.start();
    mst.put_byte(8'h68, ack);
    mst.put_byte(8'h30, ack);
    mst.put_byte(8'h3C, ack);
    mst.stop();
    mst.w(100);
    check(prog_busy_out, 1'b1);
    nrst_in = 1'b0;
    mst.w(3);
    check({sda_oe_out, prog_busy_out}, 2'b00);
    nrst_in = 1'b1;
    busy_cnt = 0;
    mst.start();
    mst.put_byte(8'h68, ack);
    check(ack, 1'b1);
    mst.put_byte(8'h30, ack);
    check(ack, 1'b1);
    mst.stop();
    mst.w(200);
    check(busy_cnt, 0);
    end_of_test();
  end
endmodule
